/* File: dv/tb_top.sv */
// Self-checking bench of the layer-4 port and flag matcher
`timescale 1ns/1ps
`default_nettype none
`include "aclpm_map.svh"

module tb_top;
   logic        mclk, rst_n, regWr, regRd, frmValid;
   logic [7:0]  regAddr, frmProto, sCtrl;
   logic [31:0] regWdata, regRdata, sSrc, sDst, seed, r;
   logic [15:0] frmSrcPort, frmDstPort, sCnt;
   logic [5:0]  frmFlags;
   logic [11:0] sFlg, fv;
   logic        resValid, resHit, resDrop, resPermit;
   logic        sHit, sDrop, expV, expHit, expDeny, hitNow;
   int          failCount = 0;
   int          checksDone = 0;
   int          cyc = 0;

   aclpm_matcher i_dut (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .frmValid, .frmProto, .frmSrcPort, .frmDstPort, .frmFlags, .resValid, .resHit,
      .resDrop, .resPermit);

   // Free-running clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Xorshift source, seeded once
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic portOk(logic [1:0] m, logic [31:0] b, logic [15:0] p);
      case (m)
         2'h0: return 1'b1;
         2'h1: return p == b[15:0];
         2'h2: return (p >= b[15:0]) && (p <= b[31:16]);
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic match(logic [7:0] pr, logic [15:0] sp, logic [15:0] dp,
                                  logic [5:0] fl);
      logic ok;
      ok = portOk(sCtrl[5:4], sSrc, sp) && portOk(sCtrl[7:6], sDst, dp);
      if (!sCtrl[0])
         return 1'b0;
      case (sCtrl[3:2])
         2'h0: return 1'b1;
         2'h1: ok = ok && (pr == `ACLPM_PROTO_TCP);
         2'h2: return ok && (pr == `ACLPM_PROTO_UDP);
         default: return 1'b0;
      endcase
      for (int i = 0; i < 6; i++) begin
         if (sFlg[2*i+:2] == {1'b0, ~fl[i]})
            ok = 1'b0;
      end
      return ok;
   endfunction

   always_comb hitNow = match(frmProto, frmSrcPort, frmDstPort, frmFlags);

   // Shadow of config and status, updated on the edges the design takes
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sCtrl <= 8'h00;
         sSrc <= 32'hFFFF0000;
         sDst <= 32'hFFFF0000;
         sFlg <= 12'hAAA;
         sCnt <= 16'h0000;
         {sHit, sDrop, expV} <= 3'h0;
      end else begin
         expV <= frmValid;
         expHit <= hitNow;
         expDeny <= sCtrl[1];
         // Status bits mirror the result register, low between frames
         sHit <= frmValid && hitNow;
         sDrop <= frmValid && hitNow && sCtrl[1];
         if (frmValid && hitNow && sCnt != 16'hFFFF)
            sCnt <= sCnt + 16'h1;
         if (regWr) begin
            case (regAddr)
               `ACLPM_OFS_CTRL: sCtrl <= regWdata[7:0];
               `ACLPM_OFS_SRC: sSrc <= regWdata;
               `ACLPM_OFS_DST: sDst <= regWdata;
               `ACLPM_OFS_FLAGS: sFlg <= regWdata[11:0];
               `ACLPM_OFS_STATUS: sCnt <= {15'h0, frmValid && hitNow};
               default: ;
            endcase
         end
      end
   end

   task automatic check(logic ok, string msg);
      checksDone++;
      if (!ok) begin
         failCount++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   // Result compare in mid-cycle
   always @(negedge mclk) begin
      if (rst_n) begin
         check(resValid === expV, "result valid");
         if (expV) begin
            check(resHit === expHit, "hit");
            check(resDrop === (expHit && expDeny), "drop");
            check(resPermit === (expHit && !expDeny), "permit");
         end
      end
   end

   task automatic regWrite(logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      frmValid <= 1'b0;
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   task automatic regRead(logic [7:0] a, logic [31:0] e);
      @(posedge mclk);
      frmValid <= 1'b0;
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      check(regRdata === e, "read data");
   endtask

   task automatic frm(logic [7:0] p, logic [15:0] s, logic [15:0] d, logic [5:0] f);
      @(posedge mclk);
      frmValid <= 1'b1;
      frmProto <= p;
      frmSrcPort <= s;
      frmDstPort <= d;
      frmFlags <= f;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failCount++;
         results();
      end
   end

   initial begin
      {rst_n, regWr, regRd, frmValid, regAddr, regWdata, frmProto} = '0;
      {frmSrcPort, frmDstPort, frmFlags} = '0;
      seed = 32'h00000055;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      regRead(`ACLPM_OFS_CTRL, 32'h0);
      regRead(`ACLPM_OFS_SRC, 32'hFFFF0000);
      regRead(`ACLPM_OFS_FLAGS, 32'hAAA);
      regRead(8'h14, 32'h0);
      $display("test reset done");
      regWrite(`ACLPM_OFS_CTRL, 32'h55);
      regWrite(`ACLPM_OFS_DST, 32'hFFFF);
      frm(`ACLPM_PROTO_TCP, 16'h0, 16'hFFFF, 6'h0);
      frm(`ACLPM_PROTO_TCP, 16'h1, 16'hFFFF, 6'h0);
      frm(`ACLPM_PROTO_TCP, 16'h0, 16'hFFFE, 6'h0);
      regWrite(`ACLPM_OFS_CTRL, 32'hA5);
      regWrite(`ACLPM_OFS_SRC, 32'h00100010);
      regWrite(`ACLPM_OFS_DST, 32'h00050009);
      frm(`ACLPM_PROTO_TCP, 16'h10, 16'h7, 6'h0);
      regWrite(`ACLPM_OFS_DST, 32'hFFFF0000);
      for (int p = 15; p < 18; p++)
         frm(`ACLPM_PROTO_TCP, 16'(p), 16'hFFFF, 6'h0);
      $display("test ports done");
      regWrite(`ACLPM_OFS_CTRL, 32'h05);
      for (int i = 0; i < 6; i++) begin
         for (int c = 0; c < 3; c++) begin
            fv = 12'hAAA;
            fv[2*i+:2] = c[1:0];
            regWrite(`ACLPM_OFS_FLAGS, {20'h0, fv});
            frm(`ACLPM_PROTO_TCP, 16'h0, 16'h0, 6'h0);
            frm(`ACLPM_PROTO_TCP, 16'h0, 16'h0, 6'h1 << i);
         end
      end
      regWrite(`ACLPM_OFS_FLAGS, 32'h555);
      regWrite(`ACLPM_OFS_CTRL, 32'h09);
      frm(`ACLPM_PROTO_UDP, 16'h0, 16'h0, 6'h0);
      frm(`ACLPM_PROTO_TCP, 16'h0, 16'h0, 6'h3F);
      $display("test flags done");
      regWrite(`ACLPM_OFS_STATUS, 32'h0);
      regWrite(`ACLPM_OFS_CTRL, 32'h03);
      frm(8'h01, 16'h0, 16'h0, 6'h0);
      frm(8'h01, 16'h0, 16'h0, 6'h0);
      regRead(`ACLPM_OFS_STATUS, {16'h2, 14'h0, 2'h3});
      regRead(`ACLPM_OFS_FLAGS, 32'h555);
      $display("test status done");
      for (int k = 0; k < 40; k++) begin
         r = rnd();
         regWrite(`ACLPM_OFS_CTRL, {24'h0, r[7:1], r[0] | r[8]});
         regWrite(`ACLPM_OFS_SRC, rnd());
         regWrite(`ACLPM_OFS_DST, rnd());
         r = rnd();
         regWrite(`ACLPM_OFS_FLAGS, {20'h0, r[11:0]});
         repeat (30) begin
            r = rnd();
            frm(r[1] ? `ACLPM_PROTO_UDP : (r[0] ? r[15:8] : `ACLPM_PROTO_TCP),
                sSrc[15:0] + 16'(r[18:16]) - 16'h2,
                sDst[15:0] + 16'(r[21:19]) - 16'h2, r[27:22]);
         end
         regRead(`ACLPM_OFS_CTRL, {24'h0, sCtrl});
         regRead(`ACLPM_OFS_STATUS, {sCnt, 14'h0, sDrop, sHit});
      end
      $display("test random done");
      results();
   end
endmodule

`default_nettype wire

/* File: verilog/aclpm_cmp_if.sv */
// Carrier between the matcher and one port comparator
`timescale 1ns/1ps
`default_nettype none

interface aclpm_cmp_if;
   import aclpm_pkg::*;
   aclpm_pmode_t mode;
   logic [15:0]  lo;
   logic [15:0]  hi;
   logic [15:0]  port;
   logic         hit;

   modport cmp (input mode, input lo, input hi, input port, output hit);
   modport user (output mode, output lo, output hi, output port, input hit);
endinterface

`default_nettype wire

/* File: verilog/aclpm_map.svh */
// Register offsets, field positions, reset values and constants of the port/flag matcher
`ifndef ACLPM_MAP_SVH
`define ACLPM_MAP_SVH

// Register byte offsets
`define ACLPM_OFS_CTRL    8'h00
`define ACLPM_OFS_SRC     8'h04
`define ACLPM_OFS_DST     8'h08
`define ACLPM_OFS_FLAGS   8'h0C
`define ACLPM_OFS_STATUS  8'h10

// Control register fields
`define ACLPM_CTRL_EN     0
`define ACLPM_CTRL_DENY   1
`define ACLPM_CTRL_PSEL   3:2
`define ACLPM_CTRL_SMODE  5:4
`define ACLPM_CTRL_DMODE  7:6

// Bound register fields, value or lower bound low, upper bound high
`define ACLPM_BND_LO      15:0
`define ACLPM_BND_HI      31:16

// Status register fields
`define ACLPM_STS_HIT     0
`define ACLPM_STS_DROP    1
`define ACLPM_STS_CNT     31:16

// Reset values
`define ACLPM_RST_FLAGS   12'hAAA
`define ACLPM_RST_LO      16'h0000
`define ACLPM_RST_HI      16'hFFFF
`define ACLPM_RST_CNT     16'h0000

// IP protocol numbers and field widths
`define ACLPM_PROTO_TCP   8'h06
`define ACLPM_PROTO_UDP   8'h11
`define ACLPM_NFLAGS      6

`endif

/* File: verilog/aclpm_matcher.sv */
// Layer-4 port and TCP flag match stage of one access_control_entry
// Behaviour
// RULE1 - TCP ports and flags only checked when ip_proto_select is TCP.
// RULE2 - UDP ports only checked when ip_proto_select is UDP.
// RULE3 - Source port criterion is any, specific value or range.
// RULE4 - Specific source mode: port must equal stored 16-bit value.
// RULE5 - Range source mode: port must lie between the stored bounds.
// RULE6 - Destination criterion has the same three modes, chosen independently.
// RULE7 - Specific destination mode: port must equal stored 16-bit value.
// RULE8 - Range destination mode: port must lie between the stored bounds.
// RULE9 - FIN setting 0 rejects FIN set, 1 requires it, any ignores.
// RULE10 - SYN setting 0 rejects SYN set, 1 requires it, any ignores.
// RULE11 - PSH setting 0 rejects PSH set, 1 requires it, any ignores.
// RULE12 - ACK setting 0 rejects ACK set, 1 requires it, any ignores.
// RULE13 - URG setting 0 rejects URG set, 1 requires it, any ignores.
// RULE14 - Matching deny entry drops the frame; permit allows forward and learning.
// RULE15 - Match only when all enabled criteria hold together; don't-care never constrains.
// RULE16 - RST flag criterion is tri-state like the other flags.
`timescale 1ns/1ps
`default_nettype none
`include "aclpm_map.svh"

module aclpm_matcher
   import aclpm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   input  wire logic        frmValid,
   input  wire logic [7:0]  frmProto,
   input  wire logic [15:0] frmSrcPort,
   input  wire logic [15:0] frmDstPort,
   input  wire logic [5:0]  frmFlags,
   output logic             resValid,
   output logic             resHit,
   output logic             resDrop,
   output logic             resPermit
);

   aclpm_state_t st;
   aclpm_state_t next_st;

   logic                      isTcp;
   logic                      isUdp;
   logic                      l4Ok;
   logic                      hitNow;
   logic [`ACLPM_NFLAGS-1:0]  flgOk;
   logic [31:0]               rdVal;

   // Whole flag field, so a plain vector can be cast onto it
   typedef aclpm_tri_t [5:0] aclpm_flg_t;

   aclpm_cmp_if srcIf ();
   aclpm_cmp_if dstIf ();

   // Source and destination comparators
   assign srcIf.mode = st.sMode;
   assign srcIf.lo   = st.sLo;
   assign srcIf.hi   = st.sHi;
   assign srcIf.port = frmSrcPort;
   assign dstIf.mode = st.dMode;
   assign dstIf.lo   = st.dLo;
   assign dstIf.hi   = st.dHi;
   assign dstIf.port = frmDstPort;

   // RULE3 source criterion
   aclpm_port_cmp u_src (
      .c (srcIf.cmp)
   );

   // RULE6 independent destination criterion
   aclpm_port_cmp u_dst (
      .c (dstIf.cmp)
   );

   // Codes 2 and 3 both leave the flag free
   // RULE9 RULE10 RULE11 RULE12 RULE13 RULE16 tri-state flags
   genvar gi;
   generate
      for (gi = 0; gi < `ACLPM_NFLAGS; gi = gi + 1) begin : g_flg
         assign flgOk[gi] = (st.flg[gi] == TRI_ZERO) ? !frmFlags[gi] :
                            (st.flg[gi] == TRI_ONE)  ?  frmFlags[gi] : 1'b1;
      end
   endgenerate

   assign isTcp = (frmProto == `ACLPM_PROTO_TCP);
   assign isUdp = (frmProto == `ACLPM_PROTO_UDP);

   // Reserved selection never matches, so a bad write fails closed
   // Protocol gating of the layer-4 criteria
   always_comb begin
      unique case (st.psel)
         PS_ANY:  l4Ok = 1'b1;
         // RULE1 TCP gating
         PS_TCP:  l4Ok = isTcp && srcIf.hit && dstIf.hit && (&flgOk);
         // RULE2 UDP gating
         PS_UDP:  l4Ok = isUdp && srcIf.hit && dstIf.hit;
         PS_RSVD: l4Ok = 1'b0;
      endcase
   end

   // RULE15 all criteria at once
   assign hitNow = frmValid && st.enable && l4Ok;

   // Status shows the result register of the cycle before the read
   // Register read mux
   always_comb begin
      unique case (regAddr)
         `ACLPM_OFS_CTRL:   rdVal = {24'h000000, st.dMode, st.sMode, st.psel,
                                     st.deny, st.enable};
         `ACLPM_OFS_SRC:    rdVal = {st.sHi, st.sLo};
         `ACLPM_OFS_DST:    rdVal = {st.dHi, st.dLo};
         `ACLPM_OFS_FLAGS:  rdVal = {20'h00000, st.flg};
         `ACLPM_OFS_STATUS: rdVal = {st.hitCnt, 14'h0000, st.resDrop, st.resHit};
         default:           rdVal = 32'h00000000;
      endcase
   end

   // Next state: bus writes, read data and match result
   always_comb begin
      next_st = st;
      if (regWr) begin
         unique case (regAddr)
            `ACLPM_OFS_CTRL: begin
               next_st.enable = regWdata[`ACLPM_CTRL_EN];
               next_st.deny   = regWdata[`ACLPM_CTRL_DENY];
               next_st.psel   = aclpm_psel_t'(regWdata[`ACLPM_CTRL_PSEL]);
               next_st.sMode  = aclpm_pmode_t'(regWdata[`ACLPM_CTRL_SMODE]);
               next_st.dMode  = aclpm_pmode_t'(regWdata[`ACLPM_CTRL_DMODE]);
            end
            `ACLPM_OFS_SRC: begin
               next_st.sLo = regWdata[`ACLPM_BND_LO];
               next_st.sHi = regWdata[`ACLPM_BND_HI];
            end
            `ACLPM_OFS_DST: begin
               next_st.dLo = regWdata[`ACLPM_BND_LO];
               next_st.dHi = regWdata[`ACLPM_BND_HI];
            end
            `ACLPM_OFS_FLAGS: next_st.flg = aclpm_flg_t'(regWdata[11:0]);
            `ACLPM_OFS_STATUS: next_st.hitCnt = `ACLPM_RST_CNT;
            default: ;
         endcase
      end
      // Hit count after clear so a hit in the clear cycle is kept
      if (hitNow && (next_st.hitCnt != 16'hFFFF)) begin
         next_st.hitCnt = next_st.hitCnt + 16'h0001;
      end
      next_st.rdata    = regRd ? rdVal : 32'h00000000;
      next_st.resValid = frmValid;
      next_st.resHit   = hitNow;
      // RULE14 deny drops, permit forwards and learns
      next_st.resDrop   = hitNow && st.deny;
      next_st.resPermit = hitNow && !st.deny;
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st           <= '0;
         st.psel      <= PS_ANY;
         st.sMode     <= PM_ANY;
         st.dMode     <= PM_ANY;
         st.sHi       <= `ACLPM_RST_HI;
         st.dHi       <= `ACLPM_RST_HI;
         st.sLo       <= `ACLPM_RST_LO;
         st.dLo       <= `ACLPM_RST_LO;
         st.flg       <= aclpm_flg_t'(`ACLPM_RST_FLAGS);
         st.hitCnt    <= `ACLPM_RST_CNT;
      end else begin
         st <= next_st;
      end
   end

   assign regRdata  = st.rdata;
   assign resValid  = st.resValid;
   assign resHit    = st.resHit;
   assign resDrop   = st.resDrop;
   assign resPermit = st.resPermit;

   // Checks on the match path
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_tcp_gate_proto: // RULE1
   assert property (resHit && $past(st.psel) == PS_TCP |-> $past(frmProto) == `ACLPM_PROTO_TCP)
      else $error("TCP entry hit on a non-TCP frame");

   a_udp_gate_proto: // RULE2
   assert property (resHit && $past(st.psel) == PS_UDP |-> $past(frmProto) == `ACLPM_PROTO_UDP)
      else $error("UDP entry hit on a non-UDP frame");

   a_any_ports_hit: // RULE3
   assert property (frmValid && st.enable && st.psel == PS_UDP && isUdp && !regWr
                    && st.sMode == PM_ANY && st.dMode == PM_ANY |=> resHit)
      else $error("Don't-care ports failed to hit");

   a_src_spec_eq: // RULE4
   assert property (resHit && $past(st.psel) != PS_ANY && $past(st.sMode) == PM_SPEC
                    |-> $past(frmSrcPort) == $past(st.sLo))
      else $error("Source value hit with unequal port");

   a_src_range_in: // RULE5
   assert property (resHit && $past(st.psel) != PS_ANY && $past(st.sMode) == PM_RANGE
                    |-> $past(frmSrcPort) >= $past(st.sLo) && $past(frmSrcPort) <= $past(st.sHi))
      else $error("Source range hit outside bounds");

   a_dst_spec_eq: // RULE6 RULE7
   assert property (resHit && $past(st.psel) != PS_ANY && $past(st.dMode) == PM_SPEC
                    |-> $past(frmDstPort) == $past(st.dLo))
      else $error("Destination value hit with unequal port");

   a_dst_range_in: // RULE8
   assert property (resHit && $past(st.psel) != PS_ANY && $past(st.dMode) == PM_RANGE
                    |-> $past(frmDstPort) >= $past(st.dLo) && $past(frmDstPort) <= $past(st.dHi))
      else $error("Destination range hit outside bounds");

   generate
      for (gi = 0; gi < `ACLPM_NFLAGS; gi = gi + 1) begin : g_fchk
         a_flag_zero_set: // RULE9 RULE10 RULE11 RULE12 RULE13 RULE16
         assert property (resHit && $past(st.psel) == PS_TCP && $past(st.flg[gi]) == TRI_ZERO
                          |-> !$past(frmFlags[gi]))
            else $error("Flag set on hit with setting zero");
         a_flag_one_clr: // RULE9 RULE10 RULE11 RULE12 RULE13 RULE16
         assert property (resHit && $past(st.psel) == PS_TCP && $past(st.flg[gi]) == TRI_ONE
                          |-> $past(frmFlags[gi]))
            else $error("Flag clear on hit with setting one");
      end
   endgenerate

   a_deny_drop_act: // RULE14
   assert property (resValid |-> (resDrop == (resHit && $past(st.deny)))
                    && (resPermit == (resHit && !$past(st.deny))))
      else $error("Action outputs disagree with entry action");

   a_hit_needs_all: // RULE15
   assert property (resHit |-> $past(frmValid) && $past(st.enable) && resValid)
      else $error("Hit without an enabled entry and valid frame");

   // Result outputs stay low between frames
   a_out_idle_low: // RULE15
   assert property (!resValid |-> !resHit && !resDrop && !resPermit)
      else $error("Result flag raised without a frame");

   a_valid_follows:
   assert property (resValid == $past(frmValid))
      else $error("Result valid not one cycle after frame valid");

   a_disabled_no_hit: // RULE15
   assert property (frmValid && !st.enable |=> !resHit)
      else $error("Disabled entry reported a hit");

   a_any_psel_hit: // RULE15
   assert property (frmValid && st.enable && st.psel == PS_ANY |=> resHit)
      else $error("Protocol don't-care entry missed a frame");

   a_rsvd_psel_miss: // RULE15
   assert property (resHit |-> $past(st.psel) != PS_RSVD)
      else $error("Reserved protocol selection reported a hit");

   a_rsvd_mode_miss: // RULE3 RULE6
   assert property (resHit && $past(st.psel) != PS_ANY
                    |-> $past(st.sMode) != PM_RSVD && $past(st.dMode) != PM_RSVD)
      else $error("Reserved port mode reported a hit");

   a_udp_flags_free: // RULE1
   assert property (frmValid && st.enable && st.psel == PS_UDP && isUdp
                    && srcIf.hit && dstIf.hit |=> resHit)
      else $error("Flag settings blocked a UDP frame");

   a_tcp_all_hit: // RULE15
   assert property (frmValid && st.enable && st.psel == PS_TCP && isTcp
                    && srcIf.hit && dstIf.hit && (&flgOk) |=> resHit)
      else $error("TCP frame meeting every criterion missed");

   a_drop_permit_excl: // RULE14
   assert property (!(resDrop && resPermit))
      else $error("Drop and permit raised together");

   // Read data and hit counter
   a_rdata_idle_zero:
   assert property (!$past(regRd) |-> regRdata == 32'h00000000)
      else $error("Read data not zero outside a read");

   a_cnt_step_hit: // RULE15
   assert property (!(regWr && regAddr == `ACLPM_OFS_STATUS) && st.hitCnt != 16'hFFFF
                    |=> st.hitCnt == $past(st.hitCnt) + {15'h0000, $past(hitNow)})
      else $error("Hit counter did not follow the hits");

   a_cnt_clear_set:
   assert property (regWr && regAddr == `ACLPM_OFS_STATUS
                    |=> st.hitCnt == {15'h0000, $past(hitNow)})
      else $error("Counter clear lost a hit in the same cycle");

   c_any_hit:  cover property (resHit && $past(st.psel) == PS_ANY);
   c_tcp_hit:  cover property (resHit && $past(st.psel) == PS_TCP);
   c_udp_hit:  cover property (resHit && $past(st.psel) == PS_UDP);
   c_drop:     cover property (resDrop);
   c_rng_miss: cover property (resValid && !resHit && $past(st.sMode) == PM_RANGE);

endmodule

`default_nettype wire

/* File: verilog/aclpm_pkg.sv */
// Types shared by the port/flag matcher modules
package aclpm_pkg;

   // Port criterion modes
   typedef enum logic [1:0] {PM_ANY, PM_SPEC, PM_RANGE, PM_RSVD} aclpm_pmode_t;

   // Protocol selection of the entry
   typedef enum logic [1:0] {PS_ANY, PS_TCP, PS_UDP, PS_RSVD} aclpm_psel_t;

   // Tri-state flag setting
   typedef enum logic [1:0] {TRI_ZERO, TRI_ONE, TRI_ANY, TRI_ANY2} aclpm_tri_t;

   // All state of the matcher
   typedef struct packed {
      logic                  enable;
      logic                  deny;
      aclpm_psel_t           psel;
      aclpm_pmode_t          sMode;
      aclpm_pmode_t          dMode;
      logic [15:0]           sLo;
      logic [15:0]           sHi;
      logic [15:0]           dLo;
      logic [15:0]           dHi;
      aclpm_tri_t [5:0]      flg;
      logic [31:0]           rdata;
      logic                  resValid;
      logic                  resHit;
      logic                  resDrop;
      logic                  resPermit;
      logic [15:0]           hitCnt;
   } aclpm_state_t;

endpackage

/* File: verilog/aclpm_port_cmp.sv */
// One port criterion: don't-care, single value or inclusive range
`timescale 1ns/1ps
`default_nettype none

module aclpm_port_cmp
   import aclpm_pkg::*;
(
   aclpm_cmp_if.cmp c
);

   // Mode select of the comparison
   always_comb begin
      unique case (c.mode)
         PM_ANY:   c.hit = 1'b1;
         // RULE4 RULE7 value equality
         PM_SPEC:  c.hit = (c.port == c.lo);
         // RULE5 RULE8 inclusive bounds
         PM_RANGE: c.hit = (c.port >= c.lo) && (c.port <= c.hi);
         PM_RSVD:  c.hit = 1'b0;   // Reserved code never matches
      endcase
   end

endmodule

`default_nettype wire
